// >>> pmc_pkg.sv
// shared constants for the power mode controller
package pmc_pkg;
  // register byte offsets
  localparam logic [7:0] PMC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PMC_STAT_OFS = 8'h04;
  localparam logic [7:0] PMC_PULL_OFS = 8'h08;
  // control fields
  localparam int PMC_LPMS_LSB = 0;
  localparam int PMC_LPMS_W = 3;
  localparam int PMC_LPR_BIT = 3;
  localparam int PMC_RTCEN_BIT = 4;
  localparam int PMC_WKPOL_BIT = 5;
  localparam int PMC_CHG_BIT = 6;
  localparam logic [31:0] PMC_CTRL_RST = 32'h00000000;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // requested low-power mode codes
  localparam logic [2:0] PMC_SEL_SLEEP = 3'h0;
  localparam logic [2:0] PMC_SEL_STOP0 = 3'h1;
  localparam logic [2:0] PMC_SEL_STOP1 = 3'h2;
  localparam logic [2:0] PMC_SEL_STBY = 3'h3;
  // clock figures
  localparam int PMC_SYS_HZ = 40000000;
  localparam int PMC_LPRUN_MAX_HZ = 2000000;
  // divider for the low-power run processor clock, rounded up so it never exceeds the limit
  localparam int PMC_LPRUN_DIV = (PMC_SYS_HZ + PMC_LPRUN_MAX_HZ - 1) / PMC_LPRUN_MAX_HZ;
  localparam int PMC_DIV_W = 5;
  typedef enum logic [2:0] {
    PMC_RUN = 3'b000,
    PMC_SLEEP = 3'b001,
    PMC_LPRUN = 3'b010,
    PMC_LPSLEEP = 3'b011,
    PMC_STOP0 = 3'b100,
    PMC_STOP1 = 3'b101,
    PMC_STANDBY = 3'b110
  } pmc_mode_t;
endpackage

// >>> pmc_regs.sv
// axi4-lite register slave for the power mode controller
`timescale 1ns/1ps
module pmc_regs
  import pmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] status,
  input wire logic standby_wipe,
  output logic [31:0] ctrl,
  output logic [31:0] pull_cfg
);
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] ctrl_r;
  logic [31:0] pull_r;
  // address and data latched separately, either order
  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_ctrl = do_write && (awaddr_r == PMC_CTRL_OFS);
  wire wr_pull = do_write && (awaddr_r == PMC_PULL_OFS);
  wire wr_hit = wr_ctrl || wr_pull;
  wire rd_ctrl = s_axi_araddr == PMC_CTRL_OFS;
  wire rd_stat = s_axi_araddr == PMC_STAT_OFS;
  wire rd_pull = s_axi_araddr == PMC_PULL_OFS;
  wire rd_hit = rd_ctrl || rd_stat || rd_pull;
  wire [31:0] rd_mux = rd_ctrl ? ctrl_r : rd_stat ? status : rd_pull ? pull_r : 32'h00000000;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  // rtc enable and wake polarity live in the standby circuitry; losing them would break the wake
  wire [31:0] stby_keep = (32'h1 << PMC_RTCEN_BIT) | (32'h1 << PMC_WKPOL_BIT);
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_arready = !s_axi_rvalid;
  assign ctrl = ctrl_r;
  assign pull_cfg = pull_r;
  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
    end
  end
  // registers; standby wipes control except its standby fields, pull settings survive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= PMC_CTRL_RST;
    end else if (standby_wipe) begin
      ctrl_r <= (ctrl_r & stby_keep) | (PMC_CTRL_RST & ~stby_keep);
    end else if (wr_ctrl) begin
      ctrl_r <= (ctrl_r & ~wmask) | (wdata_r & wmask);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pull_r <= 32'h00000000;
    end else if (wr_pull) begin
      pull_r <= (pull_r & ~wmask) | (wdata_r & wmask);
    end
  end
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> pmc_wake.sv
// standby wake-source detector
`timescale 1ns/1ps
module pmc_wake
  import pmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wakeup_pin,
  input wire logic wake_rising,
  input wire logic rtc_event,
  input wire logic lse_fail,
  input wire logic watchdog_reset,
  input wire logic ext_reset,
  output logic standby_exit
);
  logic pin_d_r;
  // edge on the wakeup pin, polarity selectable
  wire rise = wakeup_pin && !pin_d_r;
  wire fall = !wakeup_pin && pin_d_r;
  wire pin_edge = wake_rising ? rise : fall;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= wakeup_pin;
    end
  end
  assign standby_exit = pin_edge || rtc_event || lse_fail || watchdog_reset || ext_reset;
endmodule

// >>> pmc_top.sv
// power mode controller: mode sequencing, regulators, clocks, reset-time pins
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
#(
  parameter int NUM_IO = 16,
  parameter int NUM_TRIG = 8,
  parameter logic [NUM_TRIG-1:0] TRIG_IN_SLEEP = {NUM_TRIG{1'b1}}
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wfi_req,
  input wire logic wake_event,
  input wire logic periph_osc_req,
  input wire logic supply_low,
  input wire logic ext_reset,
  input wire logic watchdog_reset,
  input wire logic sw_reset,
  input wire logic wakeup_pin,
  input wire logic rtc_event,
  input wire logic lse_fail,
  input wire logic main_supply_ok,
  input wire logic backup_supply_ok,
  input wire logic hard_fault,
  input wire logic [NUM_TRIG-1:0] trig_in,
  output logic [NUM_TRIG-1:0] trig_out,
  output logic hard_fault_break,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic kernel_osc_allow,
  output logic main_regulator_en,
  output logic low_power_regulator_en,
  output logic regulator_hiz,
  output logic pll_en,
  output logic internal_16mhz_osc_en,
  output logic external_crystal_osc_en,
  output logic low_speed_crystal_osc_en,
  output logic low_speed_internal_osc_en,
  output logic rtc_en,
  output logic retain,
  output logic [NUM_IO-1:0] io_pull_up,
  output logic [NUM_IO-1:0] io_pull_down,
  output logic schmitt_en,
  output logic system_reset_n,
  output logic reset_pin_pullup_en,
  output logic backup_on_main,
  output logic charge_en,
  output logic backup_mode
);
  pmc_mode_t mode_r;
  pmc_mode_t mode_nxt;
  logic [PMC_DIV_W-1:0] div_r;
  logic reset_hold_r;
  logic internal_src_r;
  logic [31:0] ctrl;
  logic [31:0] pull_cfg;
  logic standby_exit;

  // status word: backup flag, last reset source, mode, input stage enable
  wire [31:0] status_word = {26'h0, backup_mode, internal_src_r, mode_r, schmitt_en};

  // reset sources; supply threshold reset always active, even in standby
  wire internal_rst = watchdog_reset || sw_reset || supply_low;
  wire any_rst = !aresetn || ext_reset || internal_rst;

  // control fields
  wire [PMC_LPMS_W-1:0] sel = ctrl[PMC_LPMS_LSB +: PMC_LPMS_W];
  wire lpr_req = ctrl[PMC_LPR_BIT];
  wire rtc_cfg = ctrl[PMC_RTCEN_BIT];
  wire wake_rising = ctrl[PMC_WKPOL_BIT];
  wire charge_req = ctrl[PMC_CHG_BIT];

  wire in_run = (mode_r == PMC_RUN) || (mode_r == PMC_LPRUN);
  wire in_sleep = (mode_r == PMC_SLEEP) || (mode_r == PMC_LPSLEEP);
  wire in_stop = (mode_r == PMC_STOP0) || (mode_r == PMC_STOP1);
  wire in_stby = mode_r == PMC_STANDBY;
  wire low_pwr = (mode_r == PMC_LPRUN) || (mode_r == PMC_LPSLEEP) || in_stop;

  wire wake_ok = wake_event && !backup_mode;

  pmc_wake u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .wakeup_pin(wakeup_pin),
    .wake_rising(wake_rising),
    .rtc_event(rtc_event && !backup_mode),
    .lse_fail(lse_fail),
    .watchdog_reset(watchdog_reset),
    .ext_reset(ext_reset),
    .standby_exit(standby_exit)
  );

  pmc_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .status(status_word),
    .standby_wipe(in_stby),
    .ctrl(ctrl),
    .pull_cfg(pull_cfg)
  );

  // mode transitions
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PMC_RUN: begin
        if (wfi_req) begin
          if (sel == PMC_SEL_STOP0) mode_nxt = PMC_STOP0;
          else if (sel == PMC_SEL_STOP1) mode_nxt = PMC_STOP1;
          else if (sel == PMC_SEL_STBY) mode_nxt = PMC_STANDBY;
          else mode_nxt = PMC_SLEEP;
        end else if (lpr_req) begin
          mode_nxt = PMC_LPRUN;
        end
      end
      PMC_SLEEP: if (wake_ok) mode_nxt = PMC_RUN;
      PMC_LPRUN: begin
        // low-power sleep only reached from here
        if (wfi_req) begin
          if (sel == PMC_SEL_STOP0) mode_nxt = PMC_STOP0;
          else if (sel == PMC_SEL_STOP1) mode_nxt = PMC_STOP1;
          else if (sel == PMC_SEL_STBY) mode_nxt = PMC_STANDBY;
          else mode_nxt = PMC_LPSLEEP;
        end else if (!lpr_req) begin
          mode_nxt = PMC_RUN;
        end
      end
      PMC_LPSLEEP: if (wake_ok) mode_nxt = PMC_LPRUN;
      PMC_STOP0, PMC_STOP1: if (wake_ok) mode_nxt = lpr_req ? PMC_LPRUN : PMC_RUN;
      PMC_STANDBY: if (standby_exit && !backup_mode) mode_nxt = PMC_RUN;
      default: mode_nxt = PMC_RUN;
    endcase
  end

  // mode register; every reset lands in run
  always_ff @(posedge aclk) begin
    if (any_rst) mode_r <= PMC_RUN;
    else mode_r <= mode_nxt;
  end

  // schmitt triggers stay off one cycle past reset release
  always_ff @(posedge aclk) begin
    if (any_rst) reset_hold_r <= 1'b1;
    else reset_hold_r <= 1'b0;
  end

  // remember whether the last reset came from inside
  always_ff @(posedge aclk) begin
    if (!aresetn) internal_src_r <= 1'b0;
    else if (internal_rst) internal_src_r <= 1'b1;
    else if (ext_reset) internal_src_r <= 1'b0;
  end

  // processor clock divider for low-power run, never above 2 MHz
  always_ff @(posedge aclk) begin
    if (!aresetn || div_r == PMC_DIV_W'(PMC_LPRUN_DIV - 1)) div_r <= '0;
    else div_r <= div_r + 1'b1;
  end

  // clock gating: only cpu stops in sleeps; all stop in stop/standby
  assign cpu_clk_en = (mode_r == PMC_RUN) || ((mode_r == PMC_LPRUN) && (div_r == '0));
  assign periph_clk_en = in_run || in_sleep;
  // kernel clock from 16 MHz oscillator in low-power run
  assign kernel_osc_allow = in_run || in_sleep;

  assign main_regulator_en = (mode_r == PMC_RUN) || (mode_r == PMC_SLEEP) || (mode_r == PMC_STOP0);
  assign low_power_regulator_en = low_pwr;
  assign regulator_hiz = in_stby;

  // oscillators; wake-capable peripheral may keep 16 MHz alive in stop, not in standby
  assign pll_en = !(in_stop || in_stby);
  assign internal_16mhz_osc_en = !(in_stop || in_stby) || (in_stop && periph_osc_req);
  assign external_crystal_osc_en = !(in_stop || in_stby);
  assign low_speed_crystal_osc_en = 1'b1;
  assign low_speed_internal_osc_en = 1'b1;
  assign rtc_en = (in_stby || in_stop) ? rtc_cfg : 1'b1;
  assign retain = !in_stby;

  // per-pin standby pulls, two bits per pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IO; gi = gi + 1) begin : g_pull
      assign io_pull_up[gi] = in_stby && pull_cfg[2*gi];
      assign io_pull_down[gi] = in_stby && pull_cfg[2*gi+1] && !pull_cfg[2*gi];
    end
  endgenerate

  assign system_reset_n = !any_rst;
  assign schmitt_en = !any_rst && !reset_hold_r;
  // pull-up off for internal reset source
  assign reset_pin_pullup_en = !internal_src_r;

  assign backup_on_main = main_supply_ok && backup_supply_ok;
  assign backup_mode = !main_supply_ok;
  assign charge_en = charge_req && main_supply_ok;

  generate
    for (gi = 0; gi < NUM_TRIG; gi = gi + 1) begin : g_trig
      assign trig_out[gi] = trig_in[gi] && (in_run || (in_sleep && TRIG_IN_SLEEP[gi]));
    end
  endgenerate
  assign hard_fault_break = hard_fault && in_run;
endmodule

// >>> pmc_checker.sv
// port-level assertions for the power mode controller
`timescale 1ns/1ps
module pmc_checker
  import pmc_pkg::*;
#(
  parameter int NUM_TRIG = 8
)
(
  input logic aclk,
  input logic aresetn,
  input logic supply_low,
  input logic watchdog_reset,
  input logic main_supply_ok,
  input logic backup_supply_ok,
  input logic hard_fault,
  input logic [NUM_TRIG-1:0] trig_in,
  input logic [NUM_TRIG-1:0] trig_out,
  input logic hard_fault_break,
  input logic cpu_clk_en,
  input logic periph_clk_en,
  input logic main_regulator_en,
  input logic low_power_regulator_en,
  input logic regulator_hiz,
  input logic pll_en,
  input logic internal_16mhz_osc_en,
  input logic external_crystal_osc_en,
  input logic low_speed_crystal_osc_en,
  input logic low_speed_internal_osc_en,
  input logic schmitt_en,
  input logic system_reset_n,
  input logic reset_pin_pullup_en,
  input logic backup_on_main,
  input logic charge_en
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // reset release; input stage must wait one more cycle
  sequence s_rel;
    !system_reset_n ##1 system_reset_n;
  endsequence
  AST_SLOW_OSC: assert property (low_speed_crystal_osc_en && low_speed_internal_osc_en)
    else $error("slow oscillator stopped");
  AST_STBY_OFF: assert property (regulator_hiz |-> !(main_regulator_en || low_power_regulator_en ||
    pll_en || internal_16mhz_osc_en || external_crystal_osc_en)) else $error("supply left on in standby");
  AST_SUPPLY_RST: assert property (supply_low[*2] |-> !system_reset_n)
    else $error("low supply not holding reset");
  AST_SCHM_HELD: assert property (!system_reset_n[*2] |-> !schmitt_en)
    else $error("input stage enabled in reset");
  AST_SCHM_REL: assert property (s_rel |-> !schmitt_en ##1 (schmitt_en || !system_reset_n))
    else $error("input stage timing at reset exit");
  AST_PIN_PULLUP: assert property (watchdog_reset[*2] |-> !reset_pin_pullup_en)
    else $error("pin pull-up on for internal reset");
  AST_BK_SWITCH: assert property (backup_on_main == (main_supply_ok && backup_supply_ok))
    else $error("backup switch wrong");
  AST_CHARGE: assert property (charge_en |-> main_supply_ok)
    else $error("charging without main supply");
  AST_TRIG_STOP: assert property (!periph_clk_en |-> trig_out == '0 && !hard_fault_break)
    else $error("trigger passed with clocks stopped");
  AST_HF_BREAK: assert property (hard_fault_break |-> hard_fault && (cpu_clk_en || low_power_regulator_en))
    else $error("fault break outside run modes");
  AST_LP_DIV: assert property (cpu_clk_en && low_power_regulator_en && !main_regulator_en |=>
    (!cpu_clk_en || main_regulator_en)[*8]) else $error("low-power processor clock too fast");
endmodule
bind pmc_top pmc_checker #(.NUM_TRIG(NUM_TRIG)) chk_u (.*);

// >>> pmc_src_model.sv
// model of the wake and reset sources around the controller
`timescale 1ns/1ps
module pmc_src_model (
  input logic aclk,
  input logic go,
  input logic [2:0] sel,
  output logic ext_reset,
  output logic watchdog_reset,
  output logic wakeup_pin,
  output logic rtc_event,
  output logic lse_fail
);
  logic [2:0] cnt_r = 3'h0;
  // a request holds its source four cycles, then idles low
  always_ff @(posedge aclk) begin
    if (go) begin
      cnt_r <= 3'h4;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  // one line per wake cause; pin pulse gives both edges
  assign ext_reset = cnt_r != 3'h0 && sel == 3'h0;
  assign watchdog_reset = cnt_r != 3'h0 && sel == 3'h1;
  assign wakeup_pin = cnt_r != 3'h0 && sel == 3'h2;
  assign rtc_event = cnt_r != 3'h0 && sel == 3'h3;
  assign lse_fail = cnt_r != 3'h0 && sel == 3'h4;
endmodule

// >>> test_power_mode_controller.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module test_power_mode_controller
  import pmc_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go;
  logic [7:0] s_axi_awaddr, s_axi_araddr, trig_in, trig_out;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] sel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic wfi_req, wake_event, periph_osc_req, supply_low, ext_reset, watchdog_reset, sw_reset;
  logic wakeup_pin, rtc_event, lse_fail, main_supply_ok, backup_supply_ok, hard_fault;
  logic hard_fault_break, cpu_clk_en, periph_clk_en, kernel_osc_allow, main_regulator_en;
  logic low_power_regulator_en, regulator_hiz, pll_en, internal_16mhz_osc_en, external_crystal_osc_en;
  logic low_speed_crystal_osc_en, low_speed_internal_osc_en, rtc_en, retain, schmitt_en;
  logic system_reset_n, reset_pin_pullup_en, backup_on_main, charge_en, backup_mode;
  logic [15:0] io_pull_up, io_pull_down;
  int error_cnt = 0;
  int samples_checked = 0;
  pmc_top dut_u (.*);
  pmc_src_model src_u (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    samples_checked++;
    if (v !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, v, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // wait n edges, then settle to the falling edge
  task automatic st(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [2:0] p, t;
    p = 3'b111;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (p != 3'b000) begin
      @(negedge aclk);
      t = p & {s_axi_bvalid === 1'b1, s_axi_wready === 1'b1, s_axi_awready === 1'b1};
      if (t[2]) chk(s_axi_bresp, e);
      @(posedge aclk);
      if (t[0]) s_axi_awvalid <= 1'b0;
      if (t[1]) s_axi_wvalid <= 1'b0;
      if (t[2]) s_axi_bready <= 1'b0;
      p = p & ~t;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
    logic [1:0] p, t;
    p = 2'b11;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (p != 2'b00) begin
      @(negedge aclk);
      t = p & {s_axi_rvalid === 1'b1, s_axi_arready === 1'b1};
      if (t[1]) d = s_axi_rdata;
      if (t[1]) chk(s_axi_rresp, e);
      @(posedge aclk);
      if (t[0]) s_axi_arvalid <= 1'b0;
      if (t[1]) s_axi_rready <= 1'b0;
      p = p & ~t;
    end
  endtask
  task automatic md(input pmc_mode_t m);
    logic [31:0] d;
    rd(PMC_STAT_OFS, d, AXI_OKAY);
    chk(d[3:1], m);
  endtask
  // one-cycle pulse of the wait request (w) or of a wake event
  task automatic ev(input logic w);
    @(posedge aclk);
    if (w) wfi_req <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge aclk);
    {wfi_req, wake_event} <= 2'b00;
    st(2);
  endtask
  task automatic src(input int s, input int n);
    @(posedge aclk);
    sel <= 3'(s);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    st(n);
  endtask
  task automatic cnt(output int n);
    n = 0;
    repeat (2 * PMC_LPRUN_DIV) begin
      @(negedge aclk);
      if (cpu_clk_en === 1'b1) n++;
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd(PMC_CTRL_OFS, d, AXI_OKAY);
    chk(d, PMC_CTRL_RST);
    md(PMC_RUN);
    wr(PMC_STAT_OFS, 32'h0000000E, AXI_SLVERR);
    wr(8'h0C, 32'h00000001, AXI_SLVERR);
    rd(8'h0C, d, AXI_SLVERR);
    chk(d, 32'h00000000);
  endtask
  task automatic t_sleep;
    wr(PMC_CTRL_OFS, 32'(PMC_SEL_SLEEP), AXI_OKAY);
    trig_in <= 8'hA5;
    hard_fault <= 1'b1;
    ev(1'b1);
    chk(cpu_clk_en, 1'b0);
    chk(periph_clk_en, 1'b1);
    chk(main_regulator_en, 1'b1);
    chk(trig_out, 8'hA5);
    chk(hard_fault_break, 1'b0);
    ev(1'b0);
    chk(cpu_clk_en, 1'b1);
    chk(hard_fault_break, 1'b1);
    @(posedge aclk);
    hard_fault <= 1'b0;
  endtask
  task automatic t_lp;
    int n;
    wr(PMC_CTRL_OFS, 32'h00000008, AXI_OKAY);
    md(PMC_LPRUN);
    cnt(n);
    chk(n, 2);
    chk({low_power_regulator_en, main_regulator_en}, 2'b10);
    chk(kernel_osc_allow, 1'b1);
    ev(1'b1);
    cnt(n);
    chk(n, 0);
    chk(periph_clk_en, 1'b1);
    ev(1'b0);
    md(PMC_LPRUN);
    wr(PMC_CTRL_OFS, 32'h00000000, AXI_OKAY);
    md(PMC_RUN);
  endtask
  task automatic t_stop;
    for (int i = 0; i < 2; i++) begin
      wr(PMC_CTRL_OFS, (i == 0) ? 32'(PMC_SEL_STOP0) : 32'(PMC_SEL_STOP1), AXI_OKAY);
      ev(1'b1);
      chk({periph_clk_en, cpu_clk_en, retain}, 3'b001);
      chk({pll_en, internal_16mhz_osc_en, external_crystal_osc_en}, 3'b000);
      chk({low_speed_crystal_osc_en, low_speed_internal_osc_en}, 2'b11);
      chk(main_regulator_en, i == 0);
      chk(low_power_regulator_en, 1'b1);
      chk(trig_out, 8'h00);
      @(posedge aclk);
      periph_osc_req <= 1'b1;
      st(1);
      chk(internal_16mhz_osc_en, 1'b1);
      @(posedge aclk);
      periph_osc_req <= 1'b0;
      ev(1'b0);
      md(PMC_RUN);
    end
  endtask
  task automatic t_stby;
    logic [31:0] d;
    for (int s = 0; s < 5; s++) begin
      wr(PMC_PULL_OFS, 32'h00000009, AXI_OKAY);
      wr(PMC_CTRL_OFS, 32'(PMC_SEL_STBY) | (32'(s % 2) << PMC_RTCEN_BIT), AXI_OKAY);
      ev(1'b1);
      chk({regulator_hiz, main_regulator_en, low_power_regulator_en, retain}, 4'h8);
      chk({pll_en, internal_16mhz_osc_en, external_crystal_osc_en}, 3'b000);
      chk(rtc_en, s % 2);
      chk({io_pull_down[1:0], io_pull_up[1:0]}, 4'h9);
      src(s, 8);
      chk(regulator_hiz, 1'b0);
      md(PMC_RUN);
      if (s > 1) begin
        rd(PMC_CTRL_OFS, d, AXI_OKAY);
        chk(d, 32'(s % 2) << PMC_RTCEN_BIT);
        rd(PMC_PULL_OFS, d, AXI_OKAY);
        chk(d, 32'h00000009);
      end
    end
  endtask
  task automatic t_rst;
    logic [31:0] d;
    src(1, 2);
    chk({system_reset_n, schmitt_en, reset_pin_pullup_en}, 3'b000);
    st(6);
    chk({system_reset_n, schmitt_en}, 2'b11);
    rd(PMC_STAT_OFS, d, AXI_OKAY);
    chk(d[4], 1'b1);
    src(0, 2);
    chk({system_reset_n, reset_pin_pullup_en}, 2'b01);
    st(6);
    @(posedge aclk);
    supply_low <= 1'b1;
    st(3);
    chk({system_reset_n, schmitt_en}, 2'b00);
    @(posedge aclk);
    supply_low <= 1'b0;
    st(6);
    chk(system_reset_n, 1'b1);
  endtask
  task automatic t_bk;
    wr(PMC_CTRL_OFS, 32'h00000040, AXI_OKAY);
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      {main_supply_ok, backup_supply_ok} <= 2'(k);
      st(1);
      chk(backup_on_main, k == 3);
      chk(charge_en, k > 1);
    end
    wr(PMC_CTRL_OFS, 32'(PMC_SEL_STBY), AXI_OKAY);
    ev(1'b1);
    @(posedge aclk);
    main_supply_ok <= 1'b0;
    src(3, 8);
    chk({backup_mode, regulator_hiz}, 2'b11);
    @(posedge aclk);
    main_supply_ok <= 1'b1;
    src(3, 8);
    chk({backup_mode, regulator_hiz}, 2'b00);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sel, trig_in} = 59'h0;
    {wfi_req, wake_event, periph_osc_req, supply_low, sw_reset, hard_fault} = 6'h00;
    {main_supply_ok, backup_supply_ok, aresetn} = 3'b110;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_sleep();
    t_lp();
    t_stop();
    t_stby();
    t_rst();
    t_bk();
    stop_test();
  end
  // hang guard, well beyond the few hundred cycles the run needs
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
endmodule
